// ---- diag_access.sv ----
// Diagnostic and configuration register access with serial scan port
`timescale 1ns/1ps
`include "diag_defines.svh"

module diag_access (
    // Core clock, reset, enable
    input  wire logic                 ref_clk_in,
    input  wire logic                 rstn_in,
    input  wire logic                 ce_in,
    // Register request and answer
    input  wire logic                 req_valid_in,
    input  wire diag_pkg::diag_req_t  req_in,
    output logic                      resp_valid_out,
    output diag_pkg::diag_resp_t      resp_out,
    // Fault reports
    input  wire logic                 fault_valid_in,
    input  wire diag_pkg::fault_t     fault_in,
    // Configuration to the processor
    output logic [63:0]               feature_cfg_out,
    output logic [63:0]               anc_cfg_out,
    output logic                      dump_active_out,
    // Link clock domain
    input  wire logic                 tck_in,
    input  wire logic                 link_rstn_in,
    input  wire logic                 tdi_in,
    input  wire diag_pkg::scan_op_t   scan_op_in,
    input  wire logic                 capture_in,
    input  wire logic                 shift_in,
    input  wire logic                 update_in,
    output logic                      tdo_out,
    // Processor flop chain
    input  wire logic                 chain_so_in,
    output logic                      chain_si_out,
    output logic                      chain_shift_out
);
    localparam int NSYNC = 3;
    localparam int SYNC_CFG = 0;
    localparam int SYNC_DUMP = 1;
    localparam int SYNC_ACK = 2;

    function automatic logic space_hit(input logic [7:0] spc, input logic [7:0] want,
                                       input logic [15:0] va, input logic [15:0] limit);
        return (spc == want) && (va < limit);
    endfunction

    // Core-domain state
    logic [3:0][63:0] cfg_q;
    logic [63:0]      anc_q;
    logic [63:0]      flt_status_q;
    logic [63:0]      flt_addr_q;
    logic [63:0]      arr_q [`ARR_DEPTH];
    logic [63:0]      shd_hold_q;
    logic             shd_tgl_q;
    logic [NSYNC-1:0][2:0] sync_q;
    logic [NSYNC-1:0] seen_q;
    logic [NSYNC-1:0] evt;
    logic [NSYNC-1:0] link_tgl;
    logic [63:0]      cfg_word;
    logic             shadow_ack;

    // Crossing toggles from the link domain, three stages each
    assign link_tgl[SYNC_ACK] = shadow_ack;
    genvar gs;
    generate
        for (gs = 0; gs < NSYNC; gs++) begin : g_sync
            assign evt[gs] = (sync_q[gs][1] == sync_q[gs][2]) && (sync_q[gs][2] != seen_q[gs]);
            always_ff @(posedge ref_clk_in) begin
                if (!rstn_in) begin
                    // Keep sampling so a toggle left high is not taken as new
                    sync_q[gs] <= {sync_q[gs][1:0], link_tgl[gs]};
                    seen_q[gs] <= sync_q[gs][2];
                end else if (ce_in) begin
                    sync_q[gs] <= {sync_q[gs][1:0], link_tgl[gs]};
                    if (evt[gs]) begin
                        seen_q[gs] <= sync_q[gs][2];
                    end
                end
            end
        end
    endgenerate

    // Request decode
    wire diag_pkg::diag_req_t r = req_in;
    wire take      = req_valid_in && ce_in;
    wire size_ok   = (r.size == `REG_BYTES);
    wire align_ok  = size_ok && (r.ancillary || r.va[`ALIGN_MSB:0] == `ALIGN_LSBS);
    wire anc_hit   = r.ancillary && (r.anc_num == `ANC_CFG);
    wire cfg_hit   = !r.ancillary && space_hit(r.spc, `SPC_CFG, r.va, `CFG_VA_LIMIT);
    wire flt_hit   = !r.ancillary && space_hit(r.spc, `SPC_FAULT, r.va, `FLT_VA_LIMIT);
    wire arr_hit   = !r.ancillary && space_hit(r.spc, `SPC_ARRAY, r.va, `ARR_VA_LIMIT);
    wire clr_hit   = !r.ancillary && (r.spc == `SPC_ARRAY_CLR);
    wire mapped    = anc_hit || cfg_hit || flt_hit || arr_hit || clr_hit;
    wire [1:0] cfg_idx = r.va[`CFG_IDX_MSB:`CFG_IDX_LSB];
    wire [3:0] arr_idx = r.va[`ARR_IDX_MSB:`ARR_IDX_LSB];
    wire flt_sel_addr  = r.va[`FLT_SEL_BIT];

    // Privilege checked first, then size and alignment, then the map
    wire diag_pkg::resp_code_t code =
        !r.priv   ? diag_pkg::RESP_PRIV :
        !align_ok ? diag_pkg::RESP_ALIGN :
        !mapped   ? diag_pkg::RESP_UNMAPPED :
                    diag_pkg::RESP_OK;
    wire acc_ok = take && (code == diag_pkg::RESP_OK);
    wire wr_ok  = acc_ok && r.write;

    wire [63:0] rdata =
        anc_hit ? anc_q :
        cfg_hit ? cfg_q[cfg_idx] :
        flt_hit ? (flt_sel_addr ? flt_addr_q : flt_status_q) :
        arr_hit ? arr_q[arr_idx] : `WORD_ZERO;

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            resp_valid_out <= 1'b0;
            resp_out       <= '0;
        end else if (ce_in) begin
            resp_valid_out <= req_valid_in;
            resp_out.code  <= code;
            resp_out.rdata <= (acc_ok && !r.write) ? rdata : `WORD_ZERO;
        end
    end

    // Configuration registers; a scan-in lands in the first one
    genvar gc;
    generate
        for (gc = 0; gc < 4; gc++) begin : g_cfg
            wire sw_wr = wr_ok && cfg_hit && (cfg_idx == 2'(gc));
            wire sc_wr = evt[SYNC_CFG] && (2'(gc) == `CFG_SCAN_IDX);
            always_ff @(posedge ref_clk_in) begin
                if (!rstn_in) begin
                    cfg_q[gc] <= `CFG_RST;
                end else if (ce_in) begin
                    if (sc_wr) begin
                        cfg_q[gc] <= cfg_word;
                    end else if (sw_wr) begin
                        cfg_q[gc] <= r.wdata;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            anc_q <= `ANC_RST;
        end else if (ce_in && wr_ok && anc_hit) begin
            anc_q <= r.wdata;
        end
    end

    // Fault recording; a new fault beats a clear in the same cycle
    wire flt_wr_st = wr_ok && flt_hit && !flt_sel_addr;
    wire flt_wr_ad = wr_ok && flt_hit && flt_sel_addr;
    wire keep_v    = flt_status_q[`FLT_VALID_BIT] && !(flt_wr_st && r.wdata[`FLT_VALID_BIT]);
    wire keep_o    = flt_status_q[`FLT_OVF_BIT] && !(flt_wr_st && r.wdata[`FLT_OVF_BIT]);
    wire first_flt = fault_valid_in && !keep_v;

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            flt_status_q <= `WORD_ZERO;
            flt_addr_q   <= `WORD_ZERO;
        end else if (ce_in) begin
            flt_status_q[`FLT_VALID_BIT] <= keep_v || fault_valid_in;
            flt_status_q[`FLT_OVF_BIT]   <= keep_o || (fault_valid_in && keep_v);
            if (first_flt) begin
                flt_status_q[`FLT_CODE_MSB:`FLT_CODE_LSB] <= fault_in.code;
                flt_addr_q <= fault_in.addr;
            end else if (flt_wr_ad) begin
                flt_addr_q <= r.wdata;
            end
        end
    end

    // Array contents carry no reset; software clears them by the fast clear
    always_ff @(posedge ref_clk_in) begin
        if (ce_in && wr_ok && clr_hit) begin
            for (int i = 0; i < `ARR_DEPTH; i++) begin
                arr_q[i] <= `WORD_ZERO;
            end
        end else if (ce_in && wr_ok && arr_hit) begin
            arr_q[arr_idx] <= r.wdata;
        end
    end

    // Shadow word: reloaded only after the link side took the last one
    wire shd_free = (seen_q[SYNC_ACK] == shd_tgl_q);
    wire [63:0] shd_word = {flt_status_q[`SHADOW_HALF-1:0], cfg_q[0][`SHADOW_HALF-1:0]};

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            shd_hold_q <= `WORD_ZERO;
            shd_tgl_q  <= 1'b0;
        end else if (ce_in && shd_free) begin
            shd_hold_q <= shd_word;
            shd_tgl_q  <= ~shd_tgl_q;
        end
    end

    // Dump state lasts until the controller resets the processor
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            dump_active_out <= 1'b0;
        end else if (ce_in && evt[SYNC_DUMP]) begin
            dump_active_out <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            feature_cfg_out <= `CFG_RST;
            anc_cfg_out     <= `ANC_RST;
        end else if (ce_in) begin
            feature_cfg_out <= cfg_q[0];
            anc_cfg_out     <= anc_q;
        end
    end

    diag_scan_port u_scan (
        .tck_in          (tck_in),
        .link_rstn_in    (link_rstn_in),
        .tdi_in          (tdi_in),
        .op_in           (scan_op_in),
        .capture_in      (capture_in),
        .shift_in        (shift_in),
        .update_in       (update_in),
        .tdo_out         (tdo_out),
        .shadow_word_in  (shd_hold_q),
        .shadow_tgl_in   (shd_tgl_q),
        .shadow_ack_out  (shadow_ack),
        .cfg_word_out    (cfg_word),
        .cfg_tgl_out     (link_tgl[SYNC_CFG]),
        .dump_tgl_out    (link_tgl[SYNC_DUMP]),
        .chain_so_in     (chain_so_in),
        .chain_si_out    (chain_si_out),
        .chain_shift_out (chain_shift_out)
    );

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_unpriv_req;
        take && !r.priv;
    endsequence

    sequence s_misaligned_req;
        take && r.priv && !align_ok;
    endsequence

    a_priv_refused: assert property (
        s_unpriv_req |=> resp_valid_out && resp_out.code == diag_pkg::RESP_PRIV)
        else $error("unprivileged request not refused");

    a_priv_no_update: assert property (
        s_unpriv_req ##0 (r.write && !evt[SYNC_CFG]) |=> $stable(cfg_q) && $stable(anc_q))
        else $error("unprivileged write changed a register");

    a_align_refused: assert property (
        s_misaligned_req |=> resp_out.code == diag_pkg::RESP_ALIGN && resp_out.rdata == '0)
        else $error("misaligned request not refused");

    a_align_no_update: assert property (
        s_misaligned_req ##0 (r.write && !evt[SYNC_CFG]) |=> $stable(cfg_q) && $stable(anc_q))
        else $error("misaligned write changed a register");

    a_fault_capture: assert property (
        ce_in && fault_valid_in && !flt_status_q[`FLT_VALID_BIT] |=>
        flt_status_q[`FLT_VALID_BIT] && flt_addr_q == $past(fault_in.addr))
        else $error("fault not recorded");

    a_fault_set_wins: assert property (
        ce_in && fault_valid_in && flt_wr_st |=> flt_status_q[`FLT_VALID_BIT])
        else $error("fault lost to a clear");

    a_array_write: assert property (
        wr_ok && arr_hit |=> arr_q[$past(arr_idx)] == $past(r.wdata))
        else $error("array element not written");

    a_array_clear: assert property (
        wr_ok && clr_hit |=> arr_q[0] == '0 && arr_q[`ARR_LAST] == '0)
        else $error("array fast clear failed");

    a_cfg_write: assert property (
        wr_ok && cfg_hit && !evt[SYNC_CFG] |=> cfg_q[$past(cfg_idx)] == $past(r.wdata))
        else $error("configuration write lost");

    a_ancillary_write: assert property (
        wr_ok && anc_hit ##1 ce_in |=> anc_cfg_out == $past(r.wdata, 2))
        else $error("ancillary register write lost");

    a_scan_in_cfg: assert property (
        ce_in && evt[SYNC_CFG] |=> cfg_q[0] == $past(cfg_word))
        else $error("scanned configuration not applied");

    a_shadow_hold: assert property (
        !shd_free |=> $stable(shd_hold_q))
        else $error("shadow word moved during crossing");

    a_dump_sticky: assert property (
        ce_in && evt[SYNC_DUMP] |=> dump_active_out [*8])
        else $error("dump state not held");

endmodule

// ---- diag_defines.svh ----
// Constants for the diagnostic and configuration access block
`ifndef DIAG_DEFINES_SVH
`define DIAG_DEFINES_SVH

`define REG_BYTES       4'h8
`define ALIGN_LSBS      3'h0
`define ALIGN_MSB       2

`define SPC_CFG         8'h4A
`define SPC_FAULT       8'h4C
`define SPC_ARRAY       8'h4E
`define SPC_ARRAY_CLR   8'h4F
`define ANC_CFG         5'h18

`define CFG_VA_LIMIT    16'h0020
`define CFG_IDX_LSB     3
`define CFG_IDX_MSB     4
`define CFG_SCAN_IDX    2'h0
`define CFG_RST         64'h0000_0000_0000_0000
`define ANC_RST         64'h0000_0000_0000_0000

`define FLT_VA_LIMIT    16'h0010
`define FLT_SEL_BIT     3
`define FLT_VALID_BIT   0
`define FLT_OVF_BIT     1
`define FLT_CODE_LSB    8
`define FLT_CODE_MSB    15

`define ARR_VA_LIMIT    16'h0080
`define ARR_IDX_LSB     3
`define ARR_IDX_MSB     6
`define ARR_DEPTH       16
`define ARR_LAST        4'hF

`define WORD_ZERO       64'h0000_0000_0000_0000
`define SHADOW_HALF     32

`endif

// ---- diag_pkg.sv ----
// Types shared by the diagnostic access block and its scan port
package diag_pkg;

    typedef enum logic [1:0] {
        RESP_OK,
        RESP_PRIV,
        RESP_ALIGN,
        RESP_UNMAPPED
    } resp_code_t;

    typedef enum logic [1:0] {
        SCAN_BYPASS,
        SCAN_SHADOW,
        SCAN_CONFIG,
        SCAN_DUMP
    } scan_op_t;

    typedef struct packed {
        logic        write;
        logic        priv;
        logic        ancillary;
        logic [4:0]  anc_num;
        logic [7:0]  spc;
        logic [15:0] va;
        logic [3:0]  size;
        logic [63:0] wdata;
    } diag_req_t;

    typedef struct packed {
        resp_code_t  code;
        logic [63:0] rdata;
    } diag_resp_t;

    typedef struct packed {
        logic [7:0]  code;
        logic [63:0] addr;
    } fault_t;

endpackage

// ---- diag_scan_port.sv ----
// Serial test port logic running on the link clock
`timescale 1ns/1ps
`include "diag_defines.svh"

module diag_scan_port (
    // Link clock and reset
    input  wire logic               tck_in,
    input  wire logic               link_rstn_in,
    // Serial port
    input  wire logic               tdi_in,
    input  wire diag_pkg::scan_op_t op_in,
    input  wire logic               capture_in,
    input  wire logic               shift_in,
    input  wire logic               update_in,
    output logic                    tdo_out,
    // Shadow word handshake from the core domain
    input  wire logic [63:0]        shadow_word_in,
    input  wire logic               shadow_tgl_in,
    output logic                    shadow_ack_out,
    // Requests toward the core domain
    output logic [63:0]             cfg_word_out,
    output logic                    cfg_tgl_out,
    output logic                    dump_tgl_out,
    // Processor flop chain
    input  wire logic               chain_so_in,
    output logic                    chain_si_out,
    output logic                    chain_shift_out
);
    logic [2:0]  shd_sync_q;
    logic [63:0] shd_copy_q;
    logic [63:0] sr_q;

    wire shd_new = (shd_sync_q[1] == shd_sync_q[2]) && (shd_sync_q[2] != shadow_ack_out);
    wire is_dump = (op_in == diag_pkg::SCAN_DUMP);

    // Copy taken only when the core holds the word still
    always_ff @(posedge tck_in) begin
        if (!link_rstn_in) begin
            shd_sync_q     <= 3'h0;
            shadow_ack_out <= 1'b0;
            shd_copy_q     <= `WORD_ZERO;
        end else begin
            shd_sync_q <= {shd_sync_q[1:0], shadow_tgl_in};
            if (shd_new) begin
                shadow_ack_out <= shd_sync_q[2];
                shd_copy_q     <= shadow_word_in;
            end
        end
    end

    always_ff @(posedge tck_in) begin
        if (!link_rstn_in) begin
            sr_q            <= `WORD_ZERO;
            tdo_out         <= 1'b0;
            cfg_word_out    <= `WORD_ZERO;
            cfg_tgl_out     <= 1'b0;
            dump_tgl_out    <= 1'b0;
            chain_si_out    <= 1'b0;
            chain_shift_out <= 1'b0;
        end else begin
            chain_shift_out <= shift_in && is_dump;
            chain_si_out    <= tdi_in;
            if (capture_in) begin
                sr_q <= (op_in == diag_pkg::SCAN_SHADOW) ? shd_copy_q : `WORD_ZERO;
                if (is_dump) begin
                    dump_tgl_out <= ~dump_tgl_out;
                end
            end else if (shift_in) begin
                sr_q <= {tdi_in, sr_q[63:1]};
                case (op_in)
                    diag_pkg::SCAN_DUMP:   tdo_out <= chain_so_in;
                    diag_pkg::SCAN_BYPASS: tdo_out <= tdi_in;
                    default:               tdo_out <= sr_q[0];
                endcase
            end else if (update_in && op_in == diag_pkg::SCAN_CONFIG) begin
                cfg_word_out <= sr_q;
                cfg_tgl_out  <= ~cfg_tgl_out;
            end
        end
    end

    a_dump_chain_link: assert property (@(posedge tck_in) disable iff (!link_rstn_in)
        shift_in && is_dump |=> chain_shift_out)
        else $error("dump shift did not link the flop chain");

endmodule

// ---- scan_ctrl_model.sv ----
// System controller and processor flop chain on the far side of the scan port
`timescale 1ns/1ps

module scan_ctrl_model (
    // Link clock, reset and controls
    output logic               tck_out,
    output logic               link_rstn_out,
    output logic               tdi_out,
    output diag_pkg::scan_op_t op_out,
    output logic               capture_out,
    output logic               shift_out,
    output logic               update_out,
    input  wire logic          tdo_in,
    // Processor flop chain
    input  wire logic          chain_si_in,
    input  wire logic          chain_shift_in,
    output logic               chain_so_out
);
    logic [63:0] chain_q;

    assign chain_so_out = chain_q[0];

    always @(posedge tck_out) begin
        if (chain_shift_in) begin
            chain_q <= {chain_si_in, chain_q[63:1]};
        end
    end

    initial begin
        tck_out = 1'h0;
        link_rstn_out = 1'h0;
        tdi_out = 1'h0;
        op_out = diag_pkg::SCAN_BYPASS;
        capture_out = 1'h0;
        shift_out = 1'h0;
        update_out = 1'h0;
        chain_q = '0;
    end

    // Clock only moves inside frames and the link reset
    task automatic tick();
        #24 tck_out = 1'h1;
        #24 tck_out = 1'h0;
    endtask

    task automatic link_reset();
        link_rstn_out = 1'h0;
        tick();
        tick();
        link_rstn_out = 1'h1;
    endtask

    task automatic load_chain(input logic [63:0] w);
        chain_q = w;
    endtask

    // Whole word per frame, least significant bit first
    task automatic frame(input diag_pkg::scan_op_t op, input logic [63:0] w,
                         output logic [63:0] o);
        op_out = op;
        // Idle link cycles let the shadow copy catch up with the core
        repeat (10) tick();
        capture_out = 1'h1;
        tick();
        capture_out = 1'h0;
        shift_out = 1'h1;
        for (int i = 0; i < 64; i++) begin
            tdi_out = w[i];
            tick();
            o[i] = tdo_in;
        end
        shift_out = 1'h0;
        update_out = 1'h1;
        tick();
        update_out = 1'h0;
        // Released line must not keep its last value
        tdi_out = ~tdi_out;
        tick();
    endtask
endmodule

// ---- testbench.sv ----
// Self-checking bench for the diagnostic access block
`timescale 1ns/1ps

module testbench;
    localparam logic [7:0] sp_cfg = 8'h4A;
    localparam logic [7:0] sp_flt = 8'h4C;
    localparam logic [7:0] sp_arr = 8'h4E;
    localparam logic [7:0] sp_clr = 8'h4F;
    localparam logic [7:0] anc_num = 8'h18;
    localparam logic [63:0] cfg_pat = 64'h0123_4567_89AB_CDE0;

    logic                 ref_clk_in;
    logic                 rstn_in;
    logic                 ce_in;
    logic                 req_valid_in;
    diag_pkg::diag_req_t  req_in;
    logic                 resp_valid_out;
    diag_pkg::diag_resp_t resp_out;
    logic                 fault_valid_in;
    diag_pkg::fault_t     fault_in;
    logic [63:0]          feature_cfg_out;
    logic [63:0]          anc_cfg_out;
    logic                 dump_active_out;
    logic                 tck_in;
    logic                 link_rstn_in;
    logic                 tdi_in;
    diag_pkg::scan_op_t   scan_op_in;
    logic                 capture_in;
    logic                 shift_in;
    logic                 update_in;
    logic                 tdo_out;
    logic                 chain_so_in;
    logic                 chain_si_out;
    logic                 chain_shift_out;
    int                   n_errors = 0;
    int                   n_checks = 0;
    int                   n_cyc = 0;
    logic [63:0]          o;

    diag_access diag_access_i (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
        .req_valid_in(req_valid_in), .req_in(req_in), .resp_valid_out(resp_valid_out),
        .resp_out(resp_out), .fault_valid_in(fault_valid_in), .fault_in(fault_in),
        .feature_cfg_out(feature_cfg_out), .anc_cfg_out(anc_cfg_out),
        .dump_active_out(dump_active_out), .tck_in(tck_in), .link_rstn_in(link_rstn_in),
        .tdi_in(tdi_in), .scan_op_in(scan_op_in), .capture_in(capture_in),
        .shift_in(shift_in), .update_in(update_in), .tdo_out(tdo_out),
        .chain_so_in(chain_so_in), .chain_si_out(chain_si_out),
        .chain_shift_out(chain_shift_out));

    scan_ctrl_model scan_ctrl_model_i (.tck_out(tck_in), .link_rstn_out(link_rstn_in),
        .tdi_out(tdi_in), .op_out(scan_op_in), .capture_out(capture_in),
        .shift_out(shift_in), .update_out(update_in), .tdo_in(tdo_out),
        .chain_si_in(chain_si_out), .chain_shift_in(chain_shift_out),
        .chain_so_out(chain_so_in));

    initial begin
        ref_clk_in = 1'h0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end

    task automatic wrap_up();
        if (n_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Whole run needs about 2000 core cycles
    always @(posedge ref_clk_in) begin
        n_cyc <= n_cyc + 1;
        if (n_cyc == 6000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_code(input diag_pkg::resp_code_t got, input diag_pkg::resp_code_t exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t code %0d expected %0d", $time, got, exp);
        end
    endtask

    // One request, answer checked in the cycle it stands
    task automatic acc(input logic w, input logic pv, input logic an, input logic [7:0] sp,
                       input logic [15:0] va, input logic [3:0] sz, input logic [63:0] wd,
                       input diag_pkg::resp_code_t ec, input logic [63:0] ed);
        @(posedge ref_clk_in);
        req_valid_in <= 1'h1;
        req_in <= '{w, pv, an, sp[4:0], sp, va, sz, wd};
        @(posedge ref_clk_in);
        req_valid_in <= 1'h0;
        #1;
        chk_word(64'(resp_valid_out), 64'h1);
        chk_code(resp_out.code, ec);
        chk_word(resp_out.rdata, ed);
    endtask

    task automatic wr(input logic [7:0] sp, input logic [15:0] va, input logic [63:0] wd);
        acc(1'h1, 1'h1, 1'h0, sp, va, 4'h8, wd, diag_pkg::RESP_OK, '0);
    endtask

    task automatic rd(input logic [7:0] sp, input logic [15:0] va, input logic [63:0] ed);
        acc(1'h0, 1'h1, 1'h0, sp, va, 4'h8, '0, diag_pkg::RESP_OK, ed);
    endtask

    task automatic bad(input logic pv, input logic [7:0] sp, input logic [15:0] va,
                       input logic [3:0] sz, input diag_pkg::resp_code_t ec);
        acc(1'h1, pv, 1'h0, sp, va, sz, '1, ec, '0);
    endtask

    task automatic fault(input logic [7:0] c, input logic [63:0] a);
        @(posedge ref_clk_in);
        fault_valid_in <= 1'h1;
        fault_in <= '{c, a};
        @(posedge ref_clk_in);
        fault_valid_in <= 1'h0;
    endtask

    task automatic t_cfg();
        rd(sp_cfg, 16'h0000, '0);
        for (int i = 0; i < 4; i++) wr(sp_cfg, 16'(i * 8), cfg_pat + i);
        for (int i = 0; i < 4; i++) rd(sp_cfg, 16'(i * 8), cfg_pat + i);
        chk_word(feature_cfg_out, cfg_pat);
    endtask

    task automatic t_refuse();
        bad(1'h0, sp_cfg, 16'h0008, 4'h8, diag_pkg::RESP_PRIV);
        bad(1'h0, sp_cfg, 16'h0004, 4'h4, diag_pkg::RESP_PRIV);
        bad(1'h1, sp_cfg, 16'h000C, 4'h8, diag_pkg::RESP_ALIGN);
        bad(1'h1, sp_cfg, 16'h0008, 4'h4, diag_pkg::RESP_ALIGN);
        bad(1'h0, sp_arr, 16'h0000, 4'h8, diag_pkg::RESP_PRIV);
        bad(1'h1, sp_cfg, 16'h0020, 4'h8, diag_pkg::RESP_UNMAPPED);
        bad(1'h1, sp_arr, 16'h0080, 4'h8, diag_pkg::RESP_UNMAPPED);
        acc(1'h0, 1'h1, 1'h1, 8'h17, '0, 4'h8, '0, diag_pkg::RESP_UNMAPPED, '0);
        rd(sp_cfg, 16'h0008, cfg_pat + 1);
    endtask

    task automatic t_anc();
        acc(1'h1, 1'h1, 1'h1, anc_num, '0, 4'h8, ~cfg_pat, diag_pkg::RESP_OK, '0);
        acc(1'h1, 1'h0, 1'h1, anc_num, '0, 4'h8, '0, diag_pkg::RESP_PRIV, '0);
        // Address bits play no part for ancillary registers
        acc(1'h0, 1'h1, 1'h1, anc_num, 16'h0003, 4'h8, '0, diag_pkg::RESP_OK, ~cfg_pat);
        chk_word(anc_cfg_out, ~cfg_pat);
    endtask

    task automatic t_array();
        wr(sp_arr, 16'h0000, 64'h1111_2222_3333_4444);
        wr(sp_arr, 16'h0078, 64'h5555_6666_7777_8888);
        rd(sp_arr, 16'h0000, 64'h1111_2222_3333_4444);
        rd(sp_arr, 16'h0078, 64'h5555_6666_7777_8888);
        wr(sp_clr, 16'h0000, '0);
        rd(sp_arr, 16'h0078, '0);
        rd(sp_clr, 16'h0008, '0);
    endtask

    task automatic t_fault();
        fault(8'h5A, 64'hDEAD_0000_BEEF_0008);
        rd(sp_flt, 16'h0000, 64'h0000_0000_0000_5A01);
        rd(sp_flt, 16'h0008, 64'hDEAD_0000_BEEF_0008);
        fault(8'h33, 64'h0000_0000_0000_1230);
        rd(sp_flt, 16'h0000, 64'h0000_0000_0000_5A03);
        wr(sp_flt, 16'h0000, 64'h0000_0000_0000_0003);
        // After a clear the next fault is captured anew
        fault(8'h77, 64'h0000_0000_0000_4560);
        rd(sp_flt, 16'h0000, 64'h0000_0000_0000_7701);
    endtask

    task automatic t_scan();
        logic [63:0] cw;
        cw = 64'hF0E1_D2C3_B4A5_9687;
        // Register traffic keeps running during the shadow frame
        fork
            scan_ctrl_model_i.frame(diag_pkg::SCAN_SHADOW, cw, o);
            rd(sp_cfg, 16'h0010, cfg_pat + 2);
        join
        chk_word(o, {32'h0000_7701, cfg_pat[31:0]});
        rd(sp_cfg, 16'h0000, cfg_pat);
        scan_ctrl_model_i.frame(diag_pkg::SCAN_BYPASS, cw, o);
        chk_word(o, cw);
        scan_ctrl_model_i.frame(diag_pkg::SCAN_CONFIG, cw, o);
        repeat (8) @(posedge ref_clk_in);
        rd(sp_cfg, 16'h0000, cw);
        chk_word(feature_cfg_out, cw);
    endtask

    task automatic t_dump();
        logic [63:0] cp;
        cp = 64'h8C3A_5F01_E72D_B946;
        scan_ctrl_model_i.load_chain(cp);
        scan_ctrl_model_i.frame(diag_pkg::SCAN_DUMP, '0, o);
        // Chain advances one link cycle behind the shift control
        chk_word(o, {cp[62:0], cp[0]});
        chk_word(64'(dump_active_out), 64'h1);
        @(posedge ref_clk_in);
        rstn_in <= 1'h0;
        repeat (4) @(posedge ref_clk_in);
        rstn_in <= 1'h1;
        #1;
        chk_word(64'(dump_active_out), 64'h0);
        chk_word(feature_cfg_out, '0);
        rd(sp_cfg, 16'h0000, '0);
    endtask

    initial begin
        rstn_in = 1'h0;
        ce_in = 1'h1;
        req_valid_in = 1'h0;
        req_in = '0;
        fault_valid_in = 1'h0;
        fault_in = '0;
        // Link side settles first so the core syncs fill with known values
        scan_ctrl_model_i.link_reset();
        repeat (4) @(posedge ref_clk_in);
        rstn_in <= 1'h1;
        t_cfg();
        t_refuse();
        t_anc();
        t_array();
        t_fault();
        t_scan();
        t_dump();
        wrap_up();
    end
endmodule
